// ==== rtl/timer_event_output_quad_decoder.sv ====
// Operation
// - Event source picked from three external clocks or line B.
// - Edge field picks rising, falling or both; zero means no event.
// - Event select zero: line B undriven, compare B inert.
// - External event triggers only with trigger enable set.
// - Sync, software trigger, and compare C per waveform select trigger.
// - Software trigger, event, compare C drive A and B; A/B compares own line.
// - Each event sets, clears or toggles its output by own field.
// - Line B controlled only when output and not event input.
// - Decoder uses ch0 A/B and ch1 B, drives ch0/ch1; ch2 time base.
// - Decode enable zero bypasses decoder to ordinary counting.
// - Optional index on ch1 line B; decoding works without it.
// - Clock select must be 5 (XC0), though the decoder counts with any clock select; source select ignored when decoding.
// - Position mode: ch0 counts phase edges, ch1 counts index.
// - Speed mode still counts revolutions, not position.
// - Optional input filter; polarity and phase swap configurable.
// - Compare C on ch0 or ch1 sets status flag, can interrupt.
`timescale 1ns/1ps
`default_nettype none
module timer_event_output_quad_decoder (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_clock_in_0,
    input wire logic external_clock_in_1,
    input wire logic external_clock_in_2,
    input wire logic sync_in,
    input wire logic ch0_io_line_a,
    input wire logic ch0_io_line_b,
    input wire logic ch1_io_line_b,
    output logic io_line_a,
    output logic io_line_b,
    output logic io_line_b_oe,
    output logic irq
);
    logic [31:0] channel_mode_settings;
    logic [31:0] block_mode_settings;
    logic [31:0] compare_a;
    logic [31:0] compare_b;
    logic [31:0] compare_c_value;
    logic [31:0] cnt0;
    logic [31:0] cnt1;
    logic [31:0] cnt2;
    logic [4:0] channel_status;
    logic [4:0] irq_enable;
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] prev;
    logic [2:0] filt_a_cnt;
    logic [2:0] filt_b_cnt;
    logic [2:0] filt_i_cnt;
    logic qa;
    logic qb;
    logic qi;
    logic qa_d;
    logic qb_d;
    logic qi_d;
    logic sw_trig;
    logic sync_d;
    logic acc;
    logic [31:0] rdata;
    logic ext_sig;
    logic ext_prev;
    logic ext_event;
    logic trig;
    logic cpa_hit;
    logic cpb_hit;
    logic cpc_hit;
    logic cpc_src0;
    logic quad_decode_enable;
    logic line_b_is_event;
    logic b_drive;
    logic idx_edge;
    logic step_en;
    logic step_up;
    logic clk0_edge;
    logic [4:0] events;

    function automatic logic apply_act(input logic v, input logic [1:0] a);
        unique case (a)
            2'b00: apply_act = v;
            2'b01: apply_act = 1'b1;
            2'b10: apply_act = 1'b0;
            2'b11: apply_act = ~v;
        endcase
    endfunction : apply_act

    // Two-flop synchronisers for all pins
    always_ff @(posedge clock) begin
        if (rst) begin
            s1 <= 7'h00;
            s2 <= 7'h00;
            prev <= 7'h00;
        end else begin
            s1 <= {sync_in, external_clock_in_2, external_clock_in_1,
                   external_clock_in_0, ch1_io_line_b, ch0_io_line_b,
                   ch0_io_line_a};
            s2 <= s1;
            prev <= s2;
        end
    end

    assign acc = psel && penable;
    assign quad_decode_enable = block_mode_settings[tmr_pkg::BLK_QUAD_DECODE_ENABLE_BIT];
    assign line_b_is_event = channel_mode_settings[tmr_pkg::MODE_EVT_LSB +: 2]
                             == tmr_pkg::EVT_LINE_B;

    always_ff @(posedge clock) begin
        if (rst) begin
            filt_a_cnt <= 3'h0;
            filt_b_cnt <= 3'h0;
            filt_i_cnt <= 3'h0;
            qa <= 1'b0;
            qb <= 1'b0;
            qi <= 1'b0;
        end else begin
            logic ra;
            logic rb;
            logic ri;
            ra = s2[0] ^ block_mode_settings[tmr_pkg::BLK_INVA_BIT];
            rb = s2[1] ^ block_mode_settings[tmr_pkg::BLK_INVB_BIT];
            ri = s2[2] ^ block_mode_settings[tmr_pkg::BLK_INVI_BIT];
            if (block_mode_settings[tmr_pkg::BLK_SWAP_BIT]) begin
                {ra, rb} = {rb, ra};
            end
            // Filter needs a stable level for several cycles
            if (!block_mode_settings[tmr_pkg::BLK_FILT_BIT]) begin
                qa <= ra;
                qb <= rb;
                qi <= ri;
            end else begin
                filt_a_cnt <= (ra == qa) ? 3'h0 : filt_a_cnt + 3'h1;
                filt_b_cnt <= (rb == qb) ? 3'h0 : filt_b_cnt + 3'h1;
                filt_i_cnt <= (ri == qi) ? 3'h0 : filt_i_cnt + 3'h1;
                if (filt_a_cnt == 3'(tmr_pkg::FILTER_CYCLES)) begin
                    qa <= ra;
                end
                if (filt_b_cnt == 3'(tmr_pkg::FILTER_CYCLES)) begin
                    qb <= rb;
                end
                if (filt_i_cnt == 3'(tmr_pkg::FILTER_CYCLES)) begin
                    qi <= ri;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            qa_d <= 1'b0;
            qb_d <= 1'b0;
            qi_d <= 1'b0;
            sync_d <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            qa_d <= qa;
            qb_d <= qb;
            qi_d <= qi;
            sync_d <= s2[6];
            ext_prev <= ext_sig;
        end
    end

    assign step_en = quad_decode_enable && ((qa ^ qa_d) ^ (qb ^ qb_d));
    assign step_up = (qa ^ qb_d);
    assign idx_edge = quad_decode_enable && qi && !qi_d;

    always_comb begin
        unique case (channel_mode_settings[tmr_pkg::MODE_EVT_LSB +: 2])
            2'h0: ext_sig = s2[1];
            2'h1: ext_sig = s2[3];
            2'h2: ext_sig = s2[4];
            2'h3: ext_sig = s2[5];
        endcase
    end

    always_comb begin
        unique case (channel_mode_settings[tmr_pkg::MODE_EDG_LSB +: 2])
            2'h0: ext_event = 1'b0;
            2'h1: ext_event = ext_sig && !ext_prev;
            2'h2: ext_event = !ext_sig && ext_prev;
            2'h3: ext_event = ext_sig ^ ext_prev;
        endcase
    end

    assign cpc_src0 = !block_mode_settings[tmr_pkg::BLK_RC_CH1_BIT];
    assign cpc_hit = cpc_src0 ? (cnt0 == compare_c_value)
                              : (cnt1 == compare_c_value);
    assign cpa_hit = cnt0 == compare_a;
    // compare B inert when B is event input
    assign cpb_hit = !line_b_is_event && (cnt0 == compare_b);

    assign trig = sw_trig || (s2[6] && !sync_d) ||
        (ext_event && channel_mode_settings[tmr_pkg::MODE_ETRG_BIT]) ||
        (cpc_hit && channel_mode_settings[tmr_pkg::MODE_WAVEFORM_SELECT_LSB +: 2]
                    == tmr_pkg::WAVEFORM_SELECT_UP_RC);

    // clock 0 edge; source select unused while decoding
    assign clk0_edge = (channel_mode_settings[2:0] == tmr_pkg::CLKS_XC0) &&
        (block_mode_settings[tmr_pkg::BLK_X0S_BIT] ? (s2[5] && !prev[5])
                                                   : (s2[3] && !prev[3]));

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt0 <= 32'h0000_0000;
            cnt1 <= 32'h0000_0000;
            cnt2 <= 32'h0000_0000;
        end else if (trig) begin
            cnt0 <= 32'h0000_0000;
            cnt2 <= 32'h0000_0000;
        end else begin
            cnt2 <= cnt2 + 32'h0000_0001;
            if (!quad_decode_enable) begin
                cnt0 <= clk0_edge ? cnt0 + 32'h0000_0001 : cnt0;
            end else if (block_mode_settings[tmr_pkg::BLK_POS_BIT] &&
                         step_en) begin
                cnt0 <= step_up ? cnt0 + 32'h0000_0001
                                : cnt0 - 32'h0000_0001;
            end else if (block_mode_settings[tmr_pkg::BLK_SPEED_BIT] &&
                         step_en) begin
                cnt0 <= cnt0 + 32'h0000_0001;
            end
            if (idx_edge) begin
                cnt1 <= cnt1 + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            io_line_a <= 1'b0;
            io_line_b <= 1'b0;
            io_line_b_oe <= 1'b0;
        end else begin
            logic va;
            logic vb;
            logic [31:0] m;
            m = channel_mode_settings;
            va = io_line_a;
            vb = io_line_b;
            if (cpa_hit) va = apply_act(va, m[tmr_pkg::MODE_ACPA_LSB +: 2]);
            if (cpc_hit) va = apply_act(va, m[tmr_pkg::MODE_ACPC_LSB +: 2]);
            if (ext_event) va = apply_act(va, m[tmr_pkg::MODE_AEEVT_LSB +: 2]);
            if (sw_trig) va = apply_act(va, m[tmr_pkg::MODE_ASWTRG_LSB +: 2]);
            if (cpb_hit) vb = apply_act(vb, m[tmr_pkg::MODE_BCPB_LSB +: 2]);
            if (cpc_hit) vb = apply_act(vb, m[tmr_pkg::MODE_BCPC_LSB +: 2]);
            if (ext_event) vb = apply_act(vb, m[tmr_pkg::MODE_BEEVT_LSB +: 2]);
            if (sw_trig) vb = apply_act(vb, m[tmr_pkg::MODE_BSWTRG_LSB +: 2]);
            io_line_a <= va;
            io_line_b_oe <= b_drive;
            if (b_drive) begin
                io_line_b <= vb;
            end
        end
    end
    assign b_drive = channel_mode_settings[tmr_pkg::MODE_BOUT_BIT] &&
                     !line_b_is_event;

    assign events = {idx_edge,
        ext_event && channel_mode_settings[tmr_pkg::MODE_ETRG_BIT],
        cpc_hit, cpb_hit, cpa_hit};

    always_ff @(posedge clock) begin
        if (rst) begin
            channel_status <= 5'h00;
        end else if (acc && pwrite && paddr == tmr_pkg::OFF_CLEAR) begin
            channel_status <= (channel_status & ~pwdata[4:0]) | events;
        end else begin
            channel_status <= channel_status | events;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(channel_status & irq_enable);
        end
    end

    // Register writes
    always_ff @(posedge clock) begin
        if (rst) begin
            channel_mode_settings <= tmr_pkg::MODE_RESET;
            block_mode_settings <= tmr_pkg::BLOCK_RESET;
            compare_a <= 32'h0000_0000;
            compare_b <= 32'h0000_0000;
            compare_c_value <= 32'h0000_0000;
            irq_enable <= 5'h00;
            sw_trig <= 1'b0;
        end else begin
            sw_trig <= acc && pwrite && paddr == tmr_pkg::OFF_CTRL &&
                       pwdata[0];
            if (acc && pwrite) begin
                unique case (paddr)
                    tmr_pkg::OFF_MODE: channel_mode_settings <= pwdata;
                    tmr_pkg::OFF_BLOCK: block_mode_settings <= pwdata;
                    tmr_pkg::OFF_RA: compare_a <= pwdata;
                    tmr_pkg::OFF_RB: compare_b <= pwdata;
                    tmr_pkg::OFF_RC: compare_c_value <= pwdata;
                    tmr_pkg::OFF_ENABLE: irq_enable <= pwdata[4:0];
                    default: ;
                endcase
            end
        end
    end

    always_comb begin
        unique case (paddr)
            tmr_pkg::OFF_MODE: rdata = channel_mode_settings;
            tmr_pkg::OFF_BLOCK: rdata = block_mode_settings;
            tmr_pkg::OFF_RA: rdata = compare_a;
            tmr_pkg::OFF_RB: rdata = compare_b;
            tmr_pkg::OFF_RC: rdata = compare_c_value;
            tmr_pkg::OFF_CNT0: rdata = cnt0;
            tmr_pkg::OFF_CNT1: rdata = cnt1;
            tmr_pkg::OFF_CNT2: rdata = cnt2;
            tmr_pkg::OFF_STATUS: rdata = {27'h0, channel_status};
            tmr_pkg::OFF_ENABLE: rdata = {27'h0, irq_enable};
            tmr_pkg::OFF_PINS: rdata = {29'h0, qi, qb, qa};
            default: rdata = 32'h0000_0000;
        endcase
    end

    // Zero-wait slave: answer in the access cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= rdata;
        end
    end

    property p_b_release;
        @(posedge clock) disable iff (rst)
        line_b_is_event |=> !io_line_b_oe;
    endproperty
    a_b_release: assert property (p_b_release) else $error("B driven");
    property p_b_hold;
        @(posedge clock) disable iff (rst)
        !b_drive |=> $stable(io_line_b);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("line B moved");
    property p_cpc_flag;
        @(posedge clock) disable iff (rst)
        cpc_hit |=> channel_status[tmr_pkg::ST_CPC];
    endproperty
    a_cpc_flag: assert property (p_cpc_flag) else $error("cpc lost");
    property p_bypass;
        @(posedge clock) disable iff (rst)
        !quad_decode_enable && !trig && !clk0_edge |=> $stable(cnt0);
    endproperty
    a_bypass: assert property (p_bypass) else $error("not bypassed");
    property p_no_edge;
        @(posedge clock) disable iff (rst)
        channel_mode_settings[5:4] == 2'h0 |-> !ext_event;
    endproperty
    a_no_edge: assert property (p_no_edge) else $error("no edge set");
    property p_irq;
        @(posedge clock) disable iff (rst)
        |(channel_status & irq_enable) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    c_step: cover property (@(posedge clock) step_en);
    c_index: cover property (@(posedge clock) idx_edge);
    c_trig: cover property (@(posedge clock) trig);
endmodule : timer_event_output_quad_decoder
`default_nettype wire

// ==== rtl/tmr_pkg.sv ====
package tmr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_BLOCK = 8'h04;
    localparam logic [7:0] OFF_RA = 8'h08;
    localparam logic [7:0] OFF_RB = 8'h0C;
    localparam logic [7:0] OFF_RC = 8'h10;
    localparam logic [7:0] OFF_CTRL = 8'h14;
    localparam logic [7:0] OFF_CNT0 = 8'h18;
    localparam logic [7:0] OFF_CNT1 = 8'h1C;
    localparam logic [7:0] OFF_CNT2 = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_CLEAR = 8'h28;
    localparam logic [7:0] OFF_ENABLE = 8'h2C;
    localparam logic [7:0] OFF_PINS = 8'h30;
    // Mode settings fields
    localparam int MODE_CLKS_LSB = 0;
    localparam int MODE_EDG_LSB = 4;
    localparam int MODE_EVT_LSB = 6;
    localparam int MODE_ETRG_BIT = 8;
    localparam int MODE_WAVEFORM_SELECT_LSB = 9;
    localparam int MODE_BOUT_BIT = 11;
    localparam int MODE_ACPA_LSB = 12;
    localparam int MODE_ACPC_LSB = 14;
    localparam int MODE_AEEVT_LSB = 16;
    localparam int MODE_ASWTRG_LSB = 18;
    localparam int MODE_BCPB_LSB = 20;
    localparam int MODE_BCPC_LSB = 22;
    localparam int MODE_BEEVT_LSB = 24;
    localparam int MODE_BSWTRG_LSB = 26;
    // Block mode settings fields
    localparam int BLK_X0S_BIT = 0;
    localparam int BLK_QUAD_DECODE_ENABLE_BIT = 8;
    localparam int BLK_POS_BIT = 9;
    localparam int BLK_SPEED_BIT = 10;
    localparam int BLK_INVA_BIT = 12;
    localparam int BLK_INVB_BIT = 13;
    localparam int BLK_INVI_BIT = 14;
    localparam int BLK_SWAP_BIT = 15;
    localparam int BLK_FILT_BIT = 19;
    localparam int BLK_RC_CH1_BIT = 20;
    // Status bits
    localparam int ST_CPA = 0;
    localparam int ST_CPB = 1;
    localparam int ST_CPC = 2;
    localparam int ST_ETRG = 3;
    localparam int ST_IDX = 4;
    localparam int NUM_EVENTS = 5;
    localparam logic [2:0] CLKS_XC0 = 3'h5;
    localparam logic [1:0] EVT_LINE_B = 2'h0;
    localparam logic [1:0] WAVEFORM_SELECT_UP_RC = 2'h2;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [31:0] BLOCK_RESET = 32'h0000_0000;
    localparam int FILTER_CYCLES = 3;
    typedef enum logic [1:0] {
        ACT_NONE = 2'b00,
        ACT_SET = 2'b01,
        ACT_CLEAR = 2'b10,
        ACT_TOGGLE = 2'b11
    } out_action_t;
endpackage : tmr_pkg

// ==== tb/quad_sensor.sv ====
`timescale 1ns/1ps
`default_nettype none
module quad_sensor (
    input wire logic clock,
    output logic phase_a,
    output logic phase_b,
    output logic index_out
);
    logic [1:0] pos = 2'h0;

    initial begin
        phase_a = 1'b0;
        phase_b = 1'b0;
        index_out = 1'b0;
    end

    // step of 2 moves both phases at once
    task automatic step(input logic [1:0] d, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            repeat (gap) @(posedge clock);
            pos = pos + d;
            phase_a <= pos[1] ^ pos[0];
            phase_b <= pos[1];
        end
    endtask : step

    task automatic index_pulse(input int width);
        @(posedge clock);
        index_out <= 1'b1;
        repeat (width) @(posedge clock);
        index_out <= 1'b0;
        repeat (width) @(posedge clock);
    endtask : index_pulse
endmodule : quad_sensor
`default_nettype wire

// ==== tb/test_timer_event_output_quad_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(w, e, g) begin check_count++; if ((g) !== (e)) begin \
    err_total++; $display("unexpected %s exp %h got %h", w, e, g); end end
module test_timer_event_output_quad_decoder;
    typedef struct {
        string w;
        logic [31:0] e;
        logic [31:0] m;
    } note_t;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, line_a, line_b, line_b_oe, irq;
    logic [2:0] ext = 3'h0;
    logic sync = 1'b0;
    logic ph_a, ph_b, idx;
    logic [31:0] seed = 32'hC;
    logic exp_a = 1'b0;
    tmr_pkg::out_action_t act;
    note_t cur;
    note_t notes[$];
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    int pos;
    int gap;

    initial begin
        forever #12.5 clock = ~clock;
    end

    timer_event_output_quad_decoder dut_u (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_clock_in_0(ext[0]), .external_clock_in_1(ext[1]),
        .external_clock_in_2(ext[2]), .sync_in(sync),
        .ch0_io_line_a(ph_a), .ch0_io_line_b(ph_b),
        .ch1_io_line_b(idx), .io_line_a(line_a), .io_line_b(line_b),
        .io_line_b_oe(line_b_oe), .irq(irq)
    );

    quad_sensor sensor_u (
        .clock(clock), .phase_a(ph_a), .phase_b(ph_b), .index_out(idx)
    );

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // Read notes checked where the read completes
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            wrap_up();
        end else if (psel && penable && pready === 1'b1 && !pwrite) begin
            cur = notes.pop_front();
            `CHK(cur.w, cur.e & cur.m, prdata & cur.m)
            `CHK("slverr", 1'b0, pslverr)
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Held until pready seen high
    task automatic apb(input logic we, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= we;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m, input string w);
        notes.push_back('{w, e, m});
        apb(1'b0, a, 32'h0);
    endtask : rd

    // Two-flop input sync plus decode latency
    task automatic wt();
        repeat (10) @(posedge clock);
    endtask : wt

    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        // source select set, must be ignored
        wr(tmr_pkg::OFF_MODE, {29'h0, tmr_pkg::CLKS_XC0});
        wr(tmr_pkg::OFF_BLOCK, 32'h0000_0301);
        pos = 4 + int'(rnd() % 5);
        gap = 2 + int'(rnd() % 7);
        sensor_u.step(2'h1, pos, gap);
        wt();
        rd(tmr_pkg::OFF_CNT0, 32'(pos), 32'hFFFF, "cnt up");
        sensor_u.step(2'h3, 2, 1);
        sensor_u.step(2'h2, 1, 1);
        pos -= 2;
        wt();
        rd(tmr_pkg::OFF_CNT0, 32'(pos), 32'hFFFF, "cnt down");
        wr(tmr_pkg::OFF_BLOCK, 32'h0000_0000);
        sensor_u.step(2'h1, 4, gap);
        wt();
        rd(tmr_pkg::OFF_CNT0, 32'(pos), 32'hFFFF, "bypass");
        wr(8'hFC, 32'hFFFF_FFFF);
        rd(8'hFC, 32'h0, 32'hFFFF_FFFF, "unmapped");
        $display("test position done");
        wr(tmr_pkg::OFF_BLOCK, 32'h0000_0301);
        wr(tmr_pkg::OFF_RC, 32'(pos + 2));
        wr(tmr_pkg::OFF_ENABLE, 32'h0000_0004);
        wr(tmr_pkg::OFF_CLEAR, 32'h0000_001F);
        wt();
        `CHK("irq idle", 1'b0, irq)
        sensor_u.step(2'h1, 2, gap);
        wt();
        `CHK("irq set", 1'b1, irq)
        rd(tmr_pkg::OFF_STATUS, 32'h4, 32'h4, "cmp c");
        sensor_u.step(2'h1, 1, gap);
        wt();
        `CHK("irq sticky", 1'b1, irq)
        wr(tmr_pkg::OFF_CLEAR, 32'h0000_0004);
        wt();
        `CHK("irq clear", 1'b0, irq)
        wr(tmr_pkg::OFF_ENABLE, 32'h0000_0000);
        sensor_u.step(2'h3, 1, gap);
        wt();
        `CHK("irq mask", 1'b0, irq)
        rd(tmr_pkg::OFF_STATUS, 32'h4, 32'h4, "cmp c masked");
        $display("test compare done");
        wr(tmr_pkg::OFF_BLOCK, 32'h0010_0301);
        wr(tmr_pkg::OFF_RC, 32'h0000_0002);
        wr(tmr_pkg::OFF_CLEAR, 32'h0000_001F);
        sensor_u.index_pulse(3);
        sensor_u.index_pulse(3);
        wt();
        rd(tmr_pkg::OFF_CNT1, 32'h2, 32'hFFFF, "index cnt");
        rd(tmr_pkg::OFF_STATUS, 32'h14, 32'h14, "index cmp");
        wr(tmr_pkg::OFF_BLOCK, 32'h0000_0501);
        sensor_u.index_pulse(3);
        wt();
        rd(tmr_pkg::OFF_CNT1, 32'h3, 32'hFFFF, "speed revs");
        $display("test index done");
        for (int i = 1; i < 5; i++) begin
            act = tmr_pkg::out_action_t'(i > 3 ? 3 : i);
            wr(tmr_pkg::OFF_MODE,
               32'h0000_0845 | 32'(act) << 18 | 32'(act) << 26);
            exp_a = act[0] & (~act[1] | ~exp_a);
            wr(tmr_pkg::OFF_CTRL, 32'h0000_0001);
            wt();
            `CHK("sw line a", exp_a, line_a)
            `CHK("sw line b", exp_a, line_b)
            `CHK("b driven", 1'b1, line_b_oe)
        end
        wr(tmr_pkg::OFF_MODE, 32'h0404_0805);
        wr(tmr_pkg::OFF_CTRL, 32'h0000_0001);
        wt();
        exp_a = 1'b1;
        `CHK("b released", 1'b0, line_b_oe)
        `CHK("a only", exp_a, line_a)
        $display("test outputs done");
        wr(tmr_pkg::OFF_MODE, 32'h0000_0055);
        wr(tmr_pkg::OFF_CLEAR, 32'h0000_001F);
        ext[0] <= 1'b1;
        wt();
        ext[0] <= 1'b0;
        wt();
        rd(tmr_pkg::OFF_STATUS, 32'h0, 32'h8, "no trig");
        for (int s = 1; s < 4; s++) begin
            for (int g = 0; g < 4; g++) begin
                wr(tmr_pkg::OFF_MODE,
                   32'h0003_0105 | 32'(s << 6) | 32'(g << 4));
                ext[s % 3] <= 1'b1;
                wt();
                `CHK("other src", exp_a, line_a)
                ext[s - 1] <= 1'b1;
                wt();
                exp_a ^= g[0];
                `CHK("rise", exp_a, line_a)
                ext <= 3'h0;
                wt();
                exp_a ^= g[1];
                `CHK("fall", exp_a, line_a)
            end
        end
        rd(tmr_pkg::OFF_STATUS, 32'h8, 32'h8, "trig");
        $display("test events done");
        // swap reverses count, filter passes slow edges
        wr(tmr_pkg::OFF_BLOCK, 32'h0008_8301);
        sensor_u.step(2'h1, 3, 6);
        wt();
        rd(tmr_pkg::OFF_CNT0, 32'hFFFF_FFFD, 32'hFFFF, "swap filt");
        sync <= 1'b1;
        wt();
        sync <= 1'b0;
        wt();
        rd(tmr_pkg::OFF_CNT0, 32'h0, 32'hFFFF, "sync trig");
        $display("test filter done");
        wrap_up();
    end
endmodule : test_timer_event_output_quad_decoder
`default_nettype wire
